/* File: verilog/tsf_regs.svh */
// register offsets, field positions, reset values and sizes of the filter bank
`ifndef TSF_REGS_SVH
`define TSF_REGS_SVH
`define TSF_OFF_CTRL   8'h00
`define TSF_OFF_STAT   8'h04
`define TSF_OFF_MASK   8'h08
`define TSF_OFF_PEN    8'h0C
`define TSF_OFF_THR    8'h10
`define TSF_OFF_PACT   8'h14
`define TSF_RES_BASE   2'h1
`define TSF_PRX_BASE   4'h8
`define TSF_CTRL_RAW   0
`define TSF_CTRL_POS   8
`define TSF_ST_SCAN    0
`define TSF_ST_PROX    1
`define TSF_RST_CTRL   16'h1414
`define TSF_RST_THR    16'h0100
`define TSF_NRAW       8
`define TSF_NPOS       4
`define TSF_NPRX       4
`define TSF_NSTR       12
`define TSF_RESP_OK    2'h0
`define TSF_RESP_ERR   2'h2
`endif

/* File: verilog/tsf_pkg.sv */
// shared types of the touch sample filter bank
package tsf_pkg;
    typedef enum logic [1:0] {TSF_RAW, TSF_POS, TSF_PROX} tsf_kind_e;
    typedef logic [15:0] tsf_word_t;
    // per stream-type filter selection, med in bit 0
    typedef struct packed {
        logic [1:0] wsel;
        logic       jit;
        logic       iir;
        logic       avg;
        logic       med;
    } tsf_cfg_s;
    // one scan result from the sensing front end
    typedef struct packed {
        tsf_kind_e  kind;
        logic [3:0] idx;
        tsf_word_t  data;
    } tsf_sample_s;
endpackage

/* File: verilog/tsf_median3.sv */
// middle value of three samples
`timescale 1ns/1ps
module tsf_median3
(
    // samples
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    input  wire logic [15:0] c,
    // result
    output logic      [15:0] mid
);
    wire        ab = a > b;
    wire [15:0] lo = ab ? b : a;
    wire [15:0] hi = ab ? a : b;
    wire [15:0] m2 = (hi < c) ? hi : c;

    // max(min(a,b), min(max(a,b),c)) is the median, ties included
    assign mid = (lo > m2) ? lo : m2;
endmodule

/* File: verilog/tsf_iir1.sv */
// first-order recursive step, new-sample weight 1/2 to 1/16
`timescale 1ns/1ps
module tsf_iir1
(
    // operands
    input  wire logic [15:0] prev,
    input  wire logic [15:0] x,
    input  wire logic [1:0]  wsel,
    // result
    output logic      [15:0] y
);
    logic signed [16:0] d;
    logic signed [16:0] q;

    // prev + w*(x-prev) equals (1-w)*prev + w*x; shift floors toward minus
    assign d = $signed({1'b0, x}) - $signed({1'b0, prev});
    assign q = d >>> ({1'b0, wsel} + 3'h1);
    assign y = prev + q[15:0];
endmodule

/* File: verilog/tsf_filter_bank.sv */
// touch sample filter bank with AXI4-Lite registers and interrupt
//
// Functional notes
// (RQ1) interrupt event after every finished scan
// (RQ2) filters selectable separately for raw, position
// (RQ3) median of three newest samples
// (RQ4) mean of three newest samples
// (RQ5) recursive filter mixes sample and previous output
// (RQ6) new-sample weight 1/2, 1/4, 1/8, 1/16
// (RQ7) reset: recursive 1/4 on, others off
// (RQ8) jitter output steps one toward trend
// (RQ9) jitter only for small noise, slow response
// (RQ10) separate history for every stream
// (RQ11) proximity widgets off until enabled, 16-bit
// (RQ12) proximity gives active state and count
// (RQ13) first sample seeds filter history
// (RQ14) jitter holds when sample repeats
`timescale 1ns/1ps
`include "tsf_regs.svh"
module tsf_filter_bank
    import tsf_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // front end results
    input  wire logic        IN_VALID,
    input  wire tsf_sample_s IN_SAMPLE,
    input  wire logic        SCAN_DONE,
    // filtered results
    output logic             OUT_VALID,
    output tsf_sample_s      OUT_SAMPLE,
    output logic [3:0]       PROX_SCAN_EN,
    output logic             IRQ,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    localparam int NS = `TSF_NSTR;
    localparam int NP = `TSF_NPRX;

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] strb_merge(logic [31:0] old, logic [31:0] nw,
                                               logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // ********************************
    // registers and state
    // ********************************
    logic [15:0] ctrl;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [3:0]  prox_en;
    logic [15:0] prox_thr;
    logic [3:0]  prox_act;
    tsf_word_t   prox_cnt [NP];
    tsf_word_t   med_h1   [NS];
    tsf_word_t   med_h2   [NS];
    tsf_word_t   avg_h1   [NS];
    tsf_word_t   avg_h2   [NS];
    tsf_word_t   iir_y    [NS];
    tsf_word_t   jit_last [NS];
    tsf_word_t   jit_y    [NS];
    tsf_word_t   res      [NS];
    logic [3:0]  init     [NS];
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  strb_q;
    logic        aw_full;
    logic        w_full;
    logic        cfg_touched;
    logic        wr_ctrl;

    // ********************************
    // sample decode and filter chain
    // ********************************
    wire         is_pos  = IN_SAMPLE.kind == TSF_POS;
    wire         is_raw  = IN_SAMPLE.kind == TSF_RAW;
    wire         is_prox = IN_SAMPLE.kind == TSF_PROX;
    wire         in_rng  = is_raw ? (IN_SAMPLE.idx < 4'h8) : (IN_SAMPLE.idx < 4'h4);
    wire         take    = IN_VALID && (is_raw || is_pos) && in_rng;
    wire [3:0]   s       = is_pos ? IN_SAMPLE.idx + 4'h8 : IN_SAMPLE.idx;
    // raw and position streams each have their own selection
    wire tsf_cfg_s cfg   = is_pos ? tsf_cfg_s'(ctrl[`TSF_CTRL_POS +: 6])
                                  : tsf_cfg_s'(ctrl[`TSF_CTRL_RAW +: 6]); // RQ2
    wire [3:0]   ini     = init[s];
    wire         med_act = cfg.med && ini[0];
    wire         avg_act = cfg.avg && ini[1];
    wire         iir_act = cfg.iir && ini[2];
    wire         jit_act = cfg.jit && ini[3];
    wire [15:0]  x0      = IN_SAMPLE.data;
    wire [15:0]  med_o;
    wire [15:0]  iir_o;
    wire [15:0]  x1;
    wire [15:0]  x2;
    wire [15:0]  x3;
    wire [15:0]  x4;
    wire [17:0]  avg_sum = {2'h0, x1} + {2'h0, avg_h1[s]} + {2'h0, avg_h2[s]};
    wire [17:0]  avg_q   = avg_sum / 18'h00003;
    wire [15:0]  jit_prev = jit_y[s];
    wire [15:0]  jit_ref  = jit_last[s];
    wire [15:0]  jit_o;

    tsf_median3 u_med
    (
        .a   (x0),
        .b   (med_h1[s]),
        .c   (med_h2[s]),
        .mid (med_o)
    );

    tsf_iir1 u_iir
    (
        .prev (iir_y[s]),
        .x    (x2),
        .wsel (cfg.wsel),
        .y    (iir_o)
    );

    // stages chained; a stage not yet seeded passes its input through
    assign x1 = med_act ? med_o : x0; // RQ3 RQ13
    assign x2 = avg_act ? avg_q[15:0] : x1; // RQ4
    assign x3 = iir_act ? iir_o : x2; // RQ5 RQ6
    // saturate so the one-count step never wraps
    assign jit_o = (x3 > jit_ref && jit_prev != 16'hFFFF) ? jit_prev + 16'h0001 :
                   (x3 < jit_ref && jit_prev != 16'h0000) ? jit_prev - 16'h0001 :
                   jit_prev; // RQ8 RQ14
    assign x4 = jit_act ? jit_o : x3;

    // ********************************
    // per-stream history
    // ********************************
    // histories are seeded with the sample whenever the flag is clear;
    // any control write clears every flag so a re-enabled filter never sees stale data
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int i = 0; i < NS; i++)
            begin
                med_h1[i]   <= 16'h0000;
                med_h2[i]   <= 16'h0000;
                avg_h1[i]   <= 16'h0000;
                avg_h2[i]   <= 16'h0000;
                iir_y[i]    <= 16'h0000;
                jit_last[i] <= 16'h0000;
                jit_y[i]    <= 16'h0000;
                res[i]      <= 16'h0000;
                init[i]     <= 4'h0;
            end
        end
        else
        begin
            if (take)
            begin
                med_h1[s]   <= x0; // RQ10
                med_h2[s]   <= ini[0] ? med_h1[s] : x0; // RQ13
                avg_h1[s]   <= x1;
                avg_h2[s]   <= ini[1] ? avg_h1[s] : x1;
                iir_y[s]    <= x3;
                jit_last[s] <= x3;
                jit_y[s]    <= x4;
                res[s]      <= x4;
                init[s]     <= {cfg.jit, cfg.iir, cfg.avg, cfg.med};
            end
            // the later clear overrides a seed flag set by a same-cycle sample
            if (wr_ctrl)
            begin
                for (int i = 0; i < NS; i++)
                    init[i] <= 4'h0; // RQ13
            end
        end
    end

    // filtered stream out, one cycle after the sample
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            OUT_VALID  <= 1'b0;
            OUT_SAMPLE <= '0;
        end
        else
        begin
            OUT_VALID  <= take;
            OUT_SAMPLE <= take ? {IN_SAMPLE.kind, IN_SAMPLE.idx, x4} : OUT_SAMPLE;
        end
    end

    // ********************************
    // proximity widgets
    // ********************************
    wire        prox_take = IN_VALID && is_prox && IN_SAMPLE.idx < 4'h4
                            && prox_en[IN_SAMPLE.idx[1:0]]; // RQ11
    wire        prox_on   = x0 >= prox_thr;
    wire        prox_chg  = prox_take && prox_on != prox_act[IN_SAMPLE.idx[1:0]];

    // a widget left disabled is dropped and stays out of the scan list
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            prox_act <= 4'h0;
            for (int i = 0; i < NP; i++)
                prox_cnt[i] <= 16'h0000;
        end
        else if (prox_take)
        begin
            prox_act[IN_SAMPLE.idx[1:0]] <= prox_on; // RQ12
            prox_cnt[IN_SAMPLE.idx[1:0]] <= x0;
        end
    end

    // ********************************
    // bus write path
    // ********************************
    wire        wr_fire = aw_full && w_full && !S_AXI_BVALID;
    assign      wr_ctrl = wr_fire && aw_q == `TSF_OFF_CTRL;
    wire        wr_stat = wr_fire && aw_q == `TSF_OFF_STAT;
    wire        wr_mask = wr_fire && aw_q == `TSF_OFF_MASK;
    wire        wr_pen  = wr_fire && aw_q == `TSF_OFF_PEN;
    wire        wr_thr  = wr_fire && aw_q == `TSF_OFF_THR;
    wire        wr_ok   = wr_ctrl || wr_stat || wr_mask || wr_pen || wr_thr;
    wire [31:0] wr_old  = wr_ctrl ? {16'h0000, ctrl} :
                          wr_mask ? {30'h0, mask} :
                          wr_pen  ? {28'h0, prox_en} :
                          wr_thr  ? {16'h0000, prox_thr} : 32'h0;
    wire [31:0] wr_new  = strb_merge(wr_old, w_q, strb_q);
    wire [31:0] st_word = strb_merge(32'h0, w_q, strb_q);
    wire [1:0]  st_clr  = wr_stat ? st_word[1:0] : 2'h0;
    wire [1:0]  st_set  = {prox_chg, SCAN_DONE};
    wire [1:0]  next_stat = (stat & ~st_clr) | st_set;

    // address and data are caught independently; reply once both are held
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            aw_q          <= 8'h00;
            w_q           <= 32'h0;
            strb_q        <= 4'h0;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `TSF_RESP_OK;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_q          <= {S_AXI_AWADDR[7:2], 2'h0};
                aw_full       <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_q          <= S_AXI_WDATA;
                strb_q       <= S_AXI_WSTRB;
                w_full       <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? `TSF_RESP_OK : `TSF_RESP_ERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // software registers; a hardware set beats a same-cycle clear
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl         <= `TSF_RST_CTRL; // RQ7
            stat         <= 2'h0;
            mask         <= 2'h0;
            prox_en      <= 4'h0; // RQ11
            prox_thr     <= `TSF_RST_THR;
            PROX_SCAN_EN <= 4'h0;
            IRQ          <= 1'b0;
            cfg_touched  <= 1'b0;
        end
        else
        begin
            ctrl         <= wr_ctrl ? wr_new[15:0] : ctrl;
            stat         <= next_stat; // RQ1
            mask         <= wr_mask ? wr_new[1:0] : mask;
            prox_en      <= wr_pen ? wr_new[3:0] : prox_en;
            prox_thr     <= wr_thr ? wr_new[15:0] : prox_thr;
            PROX_SCAN_EN <= wr_pen ? wr_new[3:0] : prox_en;
            IRQ          <= |(next_stat & mask);
            cfg_touched  <= cfg_touched || wr_ctrl;
        end
    end

    // ********************************
    // bus read path
    // ********************************
    wire [7:0]  ra     = {S_AXI_ARADDR[7:2], 2'h0};
    wire        ra_res = ra[7:6] == `TSF_RES_BASE && ra[5:2] < 4'(NS);
    wire        ra_prx = ra[7:4] == `TSF_PRX_BASE;
    wire        ra_reg = ra == `TSF_OFF_CTRL || ra == `TSF_OFF_STAT || ra == `TSF_OFF_MASK
                         || ra == `TSF_OFF_PEN || ra == `TSF_OFF_THR || ra == `TSF_OFF_PACT;
    wire [31:0] rd_word = ra == `TSF_OFF_CTRL ? {16'h0000, ctrl} :
                          ra == `TSF_OFF_STAT ? {30'h0, stat} :
                          ra == `TSF_OFF_MASK ? {30'h0, mask} :
                          ra == `TSF_OFF_PEN  ? {28'h0, prox_en} :
                          ra == `TSF_OFF_THR  ? {16'h0000, prox_thr} :
                          ra == `TSF_OFF_PACT ? {28'h0, prox_act} :
                          ra_res ? {16'h0000, res[ra[5:2]]} :
                          ra_prx ? {16'h0000, prox_cnt[ra[3:2]]} : 32'h0;

    // one read at a time; data is sampled at the address handshake
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `TSF_RESP_OK;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= (ra_reg || ra_res || ra_prx) ? `TSF_RESP_OK : `TSF_RESP_ERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    sequence seq_prox_off;
        IN_VALID && is_prox && IN_SAMPLE.idx < 4'h4 && !prox_en[IN_SAMPLE.idx[1:0]];
    endsequence
    sequence seq_jit_rise;
        take && jit_act && x3 > jit_ref && jit_prev != 16'hFFFF;
    endsequence

    AST_SCAN_EVENT: assert property (SCAN_DONE |=> stat[`TSF_ST_SCAN]) // RQ1
        else $error("scan end did not set status");
    AST_IRQ_LEVEL: assert property (##1 IRQ == |($past(next_stat) & $past(mask))) // RQ1
        else $error("interrupt level disagrees with status and mask");
    AST_MEDIAN: assert property (take && med_act |-> (x1 == x0 || x1 == med_h1[s]
        || x1 == med_h2[s]) && !(x1 > x0 && x1 > med_h1[s]) // RQ3
        && !(x1 < x0 && x1 < med_h1[s]))
        else $error("median stage gave an outer value");
    AST_AVERAGE: assert property (take && avg_act |-> {2'h0, x2} * 18'h3 <= avg_sum
        && avg_sum < {2'h0, x2} * 18'h3 + 18'h3) // RQ4
        else $error("average stage is not the mean of three");
    AST_IIR_RANGE: assert property (take && iir_act |-> (x3 >= x2 || x3 >= iir_y[s])
        && (x3 <= x2 || x3 <= iir_y[s])) // RQ5
        else $error("recursive output outside sample and previous output");
    AST_RESET_CFG: assert property (!cfg_touched |-> ctrl == `TSF_RST_CTRL) // RQ7
        else $error("control left its reset selection without a write");
    AST_JIT_STEP: assert property (seq_jit_rise |=> OUT_SAMPLE.data == $past(jit_prev)
        + 16'h0001) // RQ8
        else $error("jitter output did not rise by one");
    AST_JIT_HOLD: assert property (take && jit_act && x3 == jit_ref
        |=> OUT_SAMPLE.data == $past(jit_prev)) // RQ14
        else $error("jitter output moved on a repeated sample");
    AST_SEED: assert property (take && cfg.iir && !ini[2] && !cfg.jit
        |=> OUT_VALID && OUT_SAMPLE.data == $past(x2)) // RQ13
        else $error("first recursive sample was not passed through");
    AST_PROX_OFF: assert property (seq_prox_off |=> !OUT_VALID && $stable(prox_act)) // RQ11
        else $error("disabled proximity widget was processed");
    AST_PROX_STATE: assert property (prox_take |=> prox_act[$past(IN_SAMPLE.idx[1:0])]
        == ($past(x0) >= $past(prox_thr))) // RQ12
        else $error("proximity state disagrees with count and threshold");
endmodule

/* File: testbench/tsf_front_end_model.sv */
// behavioural sensing front end that feeds scan results to the filter bank
`timescale 1ns/1ps
module tsf_front_end_model
    import tsf_pkg::*;
(
    // clock
    input  wire logic   clk,
    // results toward the filter bank
    output logic        in_valid,
    output tsf_sample_s in_sample,
    output logic        scan_done
);
    // ****************************************
    // idle state and transfers
    // ****************************************
    // quiet lines at time zero, before any scan starts
    initial
    begin
        in_valid  = 1'b0;
        in_sample = '0;
        scan_done = 1'b0;
    end

    // one result; gap idle cycles first model a slow front end
    task automatic send(input tsf_kind_e k, input logic [3:0] i, input tsf_word_t d,
                        input int gap);
        begin
            repeat (gap) @(posedge clk);
            @(posedge clk);
            in_valid  <= 1'b1;
            in_sample <= '{kind: k, idx: i, data: d};
            @(posedge clk);
            in_valid       <= 1'b0;
            // stale data is inverted so nothing can lean on the released value
            in_sample.data <= ~d;
        end
    endtask

    // one end-of-scan pulse per finished measurement
    task automatic scan_end();
        begin
            @(posedge clk);
            scan_done <= 1'b1;
            @(posedge clk);
            scan_done <= 1'b0;
        end
    endtask
endmodule

/* File: testbench/tsf_filter_bank_tb_top.sv */
// self-checking bench of the touch sample filter bank
`timescale 1ns/1ps
`include "tsf_regs.svh"
`define CHK(got, want) \
    begin \
        n_compared++; \
        if ((got) !== (want)) \
        begin \
            mismatches++; \
            $display("mismatch at %0t: got %h want %h", $time, got, want); \
        end \
    end
module tsf_filter_bank_tb_top
    import tsf_pkg::*;
    ();
    logic        clk, rst_n, in_valid, scan_done, out_valid, irq;
    tsf_sample_s in_sample, out_sample;
    logic [3:0]  prox_en, wstrb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          mismatches = 0;
    int          n_compared = 0;
    // recursive outputs for 0 then three 0xA0 samples, weights 1/2 down to 1/16, floored
    tsf_word_t   iir_want [4][4] = '{'{0, 80, 120, 140}, '{0, 40, 70, 92},
                                     '{0, 20, 37, 52}, '{0, 10, 19, 27}};

    tsf_filter_bank u_dut (
        .SYS_CLK(clk), .RESET_N(rst_n), .IN_VALID(in_valid), .IN_SAMPLE(in_sample),
        .SCAN_DONE(scan_done), .OUT_VALID(out_valid), .OUT_SAMPLE(out_sample),
        .PROX_SCAN_EN(prox_en), .IRQ(irq), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    tsf_front_end_model u_fe (.clk(clk), .in_valid(in_valid), .in_sample(in_sample),
                              .scan_done(scan_done));

    // ****************************************
    // bus and stream tasks
    // ****************************************
    // 40 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // write one word; address and data are released each on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        begin
            aw_ok = 1'b0;
            w_ok  = 1'b0;
            @(posedge clk);
            awaddr  <= a;
            awvalid <= 1'b1;
            wdata   <= d;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            while (!(aw_ok && w_ok))
            begin
                @(posedge clk);
                if (awvalid && awready)
                begin
                    aw_ok = 1'b1;
                    awvalid <= 1'b0;
                end
                if (wvalid && wready)
                begin
                    w_ok = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            do @(posedge clk); while (!bvalid);
            `CHK(bresp, er)
            bready <= 1'b0;
        end
    endtask

    // read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        begin
            @(posedge clk);
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            do @(posedge clk); while (!arready);
            arvalid <= 1'b0;
            do @(posedge clk); while (!rvalid);
            `CHK(rdata, ed)
            `CHK(rresp, er)
            rready <= 1'b0;
        end
    endtask

    // four samples into one stream, each output checked one cycle after its take
    task automatic seq(input tsf_kind_e k, input logic [3:0] i, input tsf_word_t d[4],
                       input tsf_word_t e[4]);
        tsf_sample_s want;
        begin
            for (int n = 0; n < 4; n++)
            begin
                want = '{kind: k, idx: i, data: e[n]};
                u_fe.send(k, i, d[n], n % 2);
                #1;
                `CHK(out_valid, 1'b1)
                `CHK(out_sample, want)
            end
        end
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    task automatic test_done();
        begin
            $display("compared %0d, mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // ****************************************
    // tests
    // ****************************************
    // hang guard; the whole run needs well under a thousand cycles
    initial
    begin
        #(5000 * 25);
        mismatches++;
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`TSF_OFF_CTRL, 32'h0000_1414, `TSF_RESP_OK);
        rd(`TSF_OFF_MASK, 32'h0, `TSF_RESP_OK);
        rd(`TSF_OFF_PEN, 32'h0, `TSF_RESP_OK);
        rd(`TSF_OFF_THR, 32'h0000_0100, `TSF_RESP_OK);
        rd(8'h3C, 32'h0, `TSF_RESP_ERR);
        wr(`TSF_OFF_PACT, 32'hF, `TSF_RESP_ERR);
        `CHK(prox_en, 4'h0)
        note("reset");
        // default quarter weight; raw stream, its result read back, then a pos stream
        seq(TSF_RAW, 4'h0, '{100, 200, 0, 0}, '{100, 125, 93, 69});
        rd(8'h40, 32'd69, `TSF_RESP_OK);
        seq(TSF_POS, 4'h2, '{0, 64, 64, 0}, '{0, 16, 28, 21});
        note("default");
        // every weight, with reseed after each control write
        for (int w = 0; w < 4; w++)
        begin
            wr(`TSF_OFF_CTRL, 32'(4 + (w << 4)), `TSF_RESP_OK);
            seq(TSF_RAW, 4'h3, '{0, 16'hA0, 16'hA0, 16'hA0}, iir_want[w]);
        end
        note("weights");
        // median on raw only, pos passes untouched
        wr(`TSF_OFF_CTRL, 32'h0000_0001, `TSF_RESP_OK);
        seq(TSF_RAW, 4'h1, '{10, 50, 30, 5}, '{10, 10, 30, 30});
        seq(TSF_POS, 4'h0, '{50, 7, 50, 7}, '{50, 7, 50, 7});
        note("median");
        // averaging on pos only, floor of the sum over three
        wr(`TSF_OFF_CTRL, 32'h0000_0200, `TSF_RESP_OK);
        seq(TSF_POS, 4'h1, '{30, 60, 91, 0}, '{30, 40, 60, 50});
        seq(TSF_RAW, 4'h7, '{123, 9, 123, 9}, '{123, 9, 123, 9});
        note("average");
        // jitter on a slowly moving raw count with small noise only
        wr(`TSF_OFF_CTRL, 32'h0000_0008, `TSF_RESP_OK);
        seq(TSF_RAW, 4'h4, '{100, 103, 103, 99}, '{100, 101, 101, 100});
        note("jitter");
        // end-of-scan interrupt, unmasked then masked
        wr(`TSF_OFF_MASK, 32'h1, `TSF_RESP_OK);
        u_fe.scan_end();
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        rd(`TSF_OFF_STAT, 32'h1, `TSF_RESP_OK);
        wr(`TSF_OFF_STAT, 32'h1, `TSF_RESP_OK);
        repeat (2) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        wr(`TSF_OFF_MASK, 32'h0, `TSF_RESP_OK);
        u_fe.scan_end();
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        rd(`TSF_OFF_STAT, 32'h1, `TSF_RESP_OK);
        wr(`TSF_OFF_STAT, 32'h1, `TSF_RESP_OK);
        note("interrupt");
        // proximity widget dropped until enabled, then on/off against threshold
        u_fe.send(TSF_PROX, 4'h0, 16'h0200, 0);
        #1 `CHK(out_valid, 1'b0)
        rd(8'h80, 32'h0, `TSF_RESP_OK);
        wr(`TSF_OFF_PEN, 32'h1, `TSF_RESP_OK);
        `CHK(prox_en, 4'h1)
        u_fe.send(TSF_PROX, 4'h0, 16'h0200, 2);
        rd(8'h80, 32'h0000_0200, `TSF_RESP_OK);
        rd(`TSF_OFF_PACT, 32'h1, `TSF_RESP_OK);
        rd(`TSF_OFF_STAT, 32'h2, `TSF_RESP_OK);
        u_fe.send(TSF_PROX, 4'h0, 16'h00FF, 0);
        rd(`TSF_OFF_PACT, 32'h0, `TSF_RESP_OK);
        note("proximity");
        test_done();
    end
endmodule
